// File: logic/sfm_mon.sv
// Servo fault monitor with classic Wishbone register slave
// What this block does
// [R01] Bus voltage below threshold reports undervoltage
// [R02] Threshold is rated voltage times 1.414, 0.7
// [R03] Current sensor failure reports its fault code
// [R04] Encoder absent or unstable reports encoder fault
// [R05] Parameter memory read error reports memory fault
// [R06] Hall and encoder phase gap reports fault
// [R07] Mask bit 2 suppresses phase fault
// [R08] Echoed word mismatch reports link fault
// [R09] Successive current samples differing 50% fault
// [R10] Mask bit 3 suppresses current jump fault
// [R11] Wrong current direction in winding learning
// [R12] No index pulse in encoder learning
// [R13] Latest fault code held until clear
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module sfm_mon #(
   parameter int unsigned Z_WAIT_CYCLES = sfm_pkg::Z_WAIT_CYC
) (
   input  wire logic        CLK,            // System clock, 10 MHz
   input  wire logic        RST,            // Sync reset, active high
   input  wire logic        CYC_I,          // Wishbone cycle
   input  wire logic        STB_I,          // Wishbone strobe
   input  wire logic        WE_I,           // Wishbone write enable
   input  wire logic [7:0]  ADR_I,          // Wishbone byte address
   input  wire logic [3:0]  SEL_I,          // Wishbone byte lanes
   input  wire logic [31:0] DAT_I,          // Wishbone write data
   output logic      [31:0] DAT_O,          // Wishbone read data
   output logic             ACK_O,          // Wishbone acknowledge
   output logic             IRQ,            // Fault interrupt, level
   input  wire logic [15:0] BUS_VOLTAGE,    // Measured bus voltage
   input  wire logic [15:0] CUR_SAMPLE,     // Phase current, signed
   input  wire logic        CUR_VALID,      // New current sample
   input  wire logic        CUR_SENSOR_ERR, // Current sensor failed
   input  wire logic        ENC_A,          // Encoder channel A pin
   input  wire logic        ENC_B,          // Encoder channel B pin
   input  wire logic        ENC_Z,          // Encoder index pin
   input  wire logic        ENC_BREAK,      // Encoder line lost pin
   input  wire logic        NVM_RD_DONE,    // Memory read finished
   input  wire logic        NVM_RD_ERR,     // Memory read check bad
   input  wire logic [7:0]  HALL_PHASE,     // Phase from hall code
   input  wire logic [7:0]  ENC_PHASE,      // Phase from encoder
   input  wire logic        WIND_DIR,       // Learn drive positive
   input  wire logic [15:0] ECHO_IN,        // Word read from motion
   output logic      [15:0] ECHO_OUT        // Word sent to motion
);
   import sfm_pkg::*;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [16:0] sfm_abs(input logic [16:0] v);
      return v[16] ? 17'(-v) : v;
   endfunction

   function automatic logic [31:0] sfm_merge(input logic [31:0] old,
                                             input logic [31:0] wr,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = wr[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Lowest event index wins when several arrive together
   function automatic logic [7:0] sfm_pick(input sfm_ev_t ev);
      logic [7:0] c;
      c = CODE_NONE;
      if      (ev[EV_UV])    c = CODE_UV;
      else if (ev[EV_CURS])  c = CODE_CURS;
      else if (ev[EV_ENC])   c = CODE_ENC;
      else if (ev[EV_NVM])   c = CODE_NVM;
      else if (ev[EV_PHASE]) c = CODE_PHASE;
      else if (ev[EV_COMM])  c = CODE_COMM;
      else if (ev[EV_JUMP])  c = CODE_JUMP;
      else if (ev[EV_WIND])  c = CODE_WIND;
      else if (ev[EV_INDEX]) c = CODE_INDEX;
      return c;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
      logic        irq;
      logic [15:0] rated;
      logic [15:0] uv_thresh;
      logic [15:0] mask;
      logic        wlearn;
      logic        elearn;
      logic [7:0]  code;
      sfm_ev_t     status;
      sfm_ev_t     irq_mask;
      logic [15:0] comm_val;
      logic [1:0]  comm_cnt;
      logic [15:0] cur_prev;
      logic        cur_ok;
      logic [1:0]  ab_prev;
      logic        z_prev;
      logic        z_seen;
      logic        z_done;
      logic [23:0] z_cnt;
   } sfm_st_t;

   sfm_st_t     s;
   sfm_st_t     next_s;
   logic [3:0]  pins;
   sfm_ev_t     ev;
   logic        req;
   logic [32:0] uv_prod;
   logic [16:0] cur_x;
   logic [16:0] prev_x;
   logic [16:0] diff;
   logic [16:0] diff_abs;
   logic [16:0] prev_abs;
   logic [7:0]  ph_gap;
   logic [7:0]  ph_dist;
   logic [31:0] rd;

   // Encoder pins arrive from the cable, so they are synchronised
   sfm_sync #(
      .W (4)
   ) u_sync (
      .CLK  (CLK),
      .RST  (RST),
      .din  ({ENC_BREAK, ENC_Z, ENC_B, ENC_A}),
      .dout (pins)
   );

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      next_s = s;
      ev     = '0;
      req    = CYC_I & STB_I & ~s.ack;
      rd     = 32'h0000_0000;

      // Threshold registered so the multiply stays off the compare
      uv_prod           = 33'(s.rated) * 33'(UV_GAIN_Q16);    // R02
      next_s.uv_thresh  = uv_prod[31:16];                     // R02
      ev[EV_UV]         = BUS_VOLTAGE < s.uv_thresh;          // R01
      ev[EV_CURS]       = CUR_SENSOR_ERR;                     // R03

      // Line loss, or both quadrature lines toggling at once
      ev[EV_ENC] = pins[3] | ((pins[1:0] ^ s.ab_prev) == 2'b11); // R04
      next_s.ab_prev = pins[1:0];
      ev[EV_NVM] = NVM_RD_DONE & NVM_RD_ERR;                  // R05

      // Phase gap taken the short way round the circle
      ph_gap  = HALL_PHASE - ENC_PHASE;
      ph_dist = ph_gap[7] ? 8'(-ph_gap) : ph_gap;
      ev[EV_PHASE] = (ph_dist > PHASE_TOL)                    // R06
                     & ~s.mask[MASK_PHASE_BIT];               // R07

      // Echo compare once the motion side had time to settle
      if (s.comm_cnt != 2'h0) begin
         next_s.comm_cnt = s.comm_cnt - 2'h1;
         if (s.comm_cnt == 2'h1) begin
            ev[EV_COMM] = ECHO_IN != s.comm_val;              // R08
         end
      end

      // Current jump and winding direction on each new sample
      cur_x    = {CUR_SAMPLE[15], CUR_SAMPLE};
      prev_x   = {s.cur_prev[15], s.cur_prev};
      diff     = cur_x - prev_x;
      diff_abs = sfm_abs(diff);
      prev_abs = sfm_abs(prev_x);
      if (CUR_VALID) begin
         if (s.cur_ok) begin
            ev[EV_JUMP] = ({diff_abs, 1'b0} >= {1'b0, prev_abs}) // R09
                          & (prev_abs != 17'h0)
                          & ~s.mask[MASK_JUMP_BIT];           // R10
            ev[EV_WIND] = s.wlearn & (diff != 17'h0)          // R11
                          & (WIND_DIR == diff[16]);
         end
         next_s.cur_prev = CUR_SAMPLE;
         next_s.cur_ok   = 1'b1;
      end

      // Index watch: one fault per learning run if no pulse arrives
      next_s.z_prev = pins[2];
      if (!s.elearn) begin
         next_s.z_cnt  = 24'h00_0000;
         next_s.z_seen = 1'b0;
         next_s.z_done = 1'b0;
      end else begin
         if (pins[2] && !s.z_prev) begin
            next_s.z_seen = 1'b1;
         end
         if (!s.z_seen && !s.z_done) begin
            if (s.z_cnt == 24'(Z_WAIT_CYCLES - 1)) begin
               ev[EV_INDEX]  = 1'b1;                          // R12
               next_s.z_done = 1'b1;
            end else begin
               next_s.z_cnt = s.z_cnt + 24'h00_0001;
            end
         end
      end

      // Read mux
      unique case (ADR_I)
         OFS_CTRL:    rd = {29'h0, s.elearn, s.wlearn, 1'b0};
         OFS_RATED:   rd = {16'h0, s.rated};
         OFS_BUSV:    rd = {16'h0, BUS_VOLTAGE};
         OFS_MASK:    rd = {16'h0, s.mask};
         OFS_CODE:    rd = {24'h0, s.code};
         OFS_STATUS:  rd = {23'h0, s.status};
         OFS_IRQMASK: rd = {23'h0, s.irq_mask};
         OFS_COMM:    rd = {16'h0, s.comm_val};
         OFS_UVTH:    rd = {16'h0, s.uv_thresh};
         default:     rd = 32'h0000_0000;
      endcase

      // Bus slave: answer one cycle after the request, every address
      next_s.ack = req;
      if (req && !WE_I) begin
         next_s.dat = rd;
         if (ADR_I == OFS_STATUS) begin
            next_s.status = '0;
         end
      end
      if (req && WE_I) begin
         unique case (ADR_I)
            OFS_CTRL: begin
               if (SEL_I[0]) begin
                  next_s.wlearn = DAT_I[CTRL_WLEARN_BIT];
                  next_s.elearn = DAT_I[CTRL_ELEARN_BIT];
                  if (DAT_I[CTRL_CLR_BIT]) begin
                     next_s.code = CODE_NONE;                 // R13
                  end
               end
            end
            OFS_RATED:
               next_s.rated = 16'(sfm_merge(32'(s.rated), DAT_I, SEL_I));
            OFS_MASK:
               next_s.mask = 16'(sfm_merge(32'(s.mask), DAT_I, SEL_I));
            OFS_IRQMASK: begin
               if (SEL_I[0]) next_s.irq_mask[7:0] = DAT_I[7:0];
               if (SEL_I[1]) next_s.irq_mask[8]   = DAT_I[8];
            end
            OFS_COMM: begin
               next_s.comm_val =
                  16'(sfm_merge(32'(s.comm_val), DAT_I, SEL_I));
               next_s.comm_cnt = 2'(COMM_SETTLE_CYC);
            end
            default: ;
         endcase
      end

      // New events win over a read clear or a code clear
      next_s.status = next_s.status | ev;
      if (ev != '0) begin
         next_s.code = sfm_pick(ev);                          // R13
      end
      next_s.irq = |(next_s.status & next_s.irq_mask);
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (RST) begin
         s          <= '0;
         s.rated    <= RATED_RST;
         s.mask     <= MASK_RST;
         s.irq_mask <= IRQMASK_RST;
         s.code     <= CODE_NONE;
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from the state register
   assign DAT_O    = s.dat;
   assign ACK_O    = s.ack;
   assign IRQ      = s.irq;
   assign ECHO_OUT = s.comm_val;
endmodule // sfm_mon

// File: logic/sfm_pkg.sv
// Shared constants and types of the servo fault monitor
package sfm_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_HZ        = 10_000_000;
   localparam int CLK_PERIOD_NS = 100;
   // Settle time before the echoed word is compared, rounded up
   localparam int COMM_SETTLE_NS  = 300;
   localparam int COMM_SETTLE_CYC =
      (COMM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Window for the index pulse while the encoder is learning
   localparam int Z_WAIT_MS  = 500;
   localparam int Z_WAIT_CYC = Z_WAIT_MS * (CLK_HZ / 1000);

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_RATED   = 8'h04;
   localparam logic [7:0] OFS_BUSV    = 8'h08;
   localparam logic [7:0] OFS_MASK    = 8'h0c;
   localparam logic [7:0] OFS_CODE    = 8'h10;
   localparam logic [7:0] OFS_STATUS  = 8'h14;
   localparam logic [7:0] OFS_IRQMASK = 8'h18;
   localparam logic [7:0] OFS_COMM    = 8'h1c;
   localparam logic [7:0] OFS_UVTH    = 8'h20;

   // Control and mask bit positions
   localparam int CTRL_CLR_BIT    = 0;
   localparam int CTRL_WLEARN_BIT = 1;
   localparam int CTRL_ELEARN_BIT = 2;
   localparam int MASK_PHASE_BIT  = 2;
   localparam int MASK_JUMP_BIT   = 3;

   // Reset values
   localparam logic [15:0] RATED_RST   = 16'h00dc;
   localparam logic [15:0] MASK_RST    = 16'h0000;
   localparam logic [8:0]  IRQMASK_RST = 9'h000;

   // ****************************************************************
   // Fault events, their status bits and their codes
   // ****************************************************************
   localparam int EV_UV    = 0;
   localparam int EV_CURS  = 1;
   localparam int EV_ENC   = 2;
   localparam int EV_NVM   = 3;
   localparam int EV_PHASE = 4;
   localparam int EV_COMM  = 5;
   localparam int EV_JUMP  = 6;
   localparam int EV_WIND  = 7;
   localparam int EV_INDEX = 8;
   localparam int NUM_EV   = 9;
   typedef logic [NUM_EV-1:0] sfm_ev_t;

   localparam logic [7:0] CODE_NONE  = 8'h00;
   localparam logic [7:0] CODE_UV    = 8'h67;   // 103
   localparam logic [7:0] CODE_CURS  = 8'h68;   // 104
   localparam logic [7:0] CODE_ENC   = 8'h69;   // 105
   localparam logic [7:0] CODE_NVM   = 8'h6a;   // 106
   localparam logic [7:0] CODE_PHASE = 8'h6b;   // 107
   localparam logic [7:0] CODE_COMM  = 8'h6c;   // 108
   localparam logic [7:0] CODE_JUMP  = 8'h6d;   // 109
   localparam logic [7:0] CODE_WIND  = 8'h6f;   // 111
   localparam logic [7:0] CODE_INDEX = 8'h71;   // 113

   // ****************************************************************
   // Detection figures
   // ****************************************************************
   // Threshold gain rated * 1.414 * 0.7 held as a Q16 factor
   localparam int UV_PEAK_MILLI = 1414;
   localparam int UV_DERATE_TNT = 7;
   localparam int UV_GAIN_Q16   =
      (UV_PEAK_MILLI * UV_DERATE_TNT * 65536) / 10000;
   // Largest tolerated hall/encoder phase gap, 256 units per turn
   localparam logic [7:0] PHASE_TOL = 8'h2b;

endpackage : sfm_pkg

// File: logic/sfm_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module sfm_sync #(
   parameter int W = 4
) (
   input  wire logic         CLK,     // System clock
   input  wire logic         RST,     // Synchronous reset, active high
   input  wire logic [W-1:0] din,     // Asynchronous pin levels
   output logic      [W-1:0] dout     // Filtered level
);
   import sfm_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sfm_sync_st_t;

   sfm_sync_st_t s;
   sfm_sync_st_t next_s;

   // First stage feeds only the second; q moves once s2 and s3 agree
   always_comb begin
      next_s    = s;
      next_s.s1 = din;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      for (int i = 0; i < W; i++) begin
         if (s.s2[i] == s.s3[i]) begin
            next_s.q[i] = s.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge CLK) begin
      if (RST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign dout = s.q;
endmodule // sfm_sync

// File: sim/sfm_echo_model.sv
// Motion-side model that hands the processor word back
`timescale 1ns/10ps
module sfm_echo_model (
   input  wire logic        clk,      // System clock
   input  wire logic [15:0] echo_out, // Word from the monitor
   input  wire logic [15:0] flip,     // Bits corrupted on return
   output logic      [15:0] echo_in   // Word read back
);
   // One cycle late, well inside the settle time before compare
   always_ff @(posedge clk) begin
      echo_in <= echo_out ^ flip;
   end
endmodule // sfm_echo_model

// File: sim/sfm_mon_bench.sv
// Self-checking bench of the servo fault monitor
`timescale 1ns/10ps
module sfm_mon_bench;
   import sfm_pkg::*;
   localparam int ZW = 50; // Short index window keeps the run brief
   logic        CLK = 1'b0, RST = 1'b1, ACK_O, IRQ;
   logic        CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
   logic [7:0]  ADR_I = 8'h00, HALL_PHASE = 8'h00, ENC_PHASE = 8'h00;
   logic [3:0]  SEL_I = 4'hf;
   logic [31:0] DAT_I = 32'h0, DAT_O, q;
   logic        ENC_Z = 1'b0, ENC_BREAK = 1'b0, WIND_DIR = 1'b1;
   logic        ENC_A = 1'b0, ENC_B = 1'b0;
   logic        CUR_VALID = 1'b0, CUR_SENSOR_ERR = 1'b0;
   logic        NVM_RD_DONE = 1'b0, NVM_RD_ERR = 1'b0;
   logic [15:0] BUS_VOLTAGE = 16'hffff, CUR_SAMPLE = 16'h0;
   logic [15:0] ECHO_IN, ECHO_OUT, flip = 16'h0;
   int          err_total = 0, num_checks = 0;

   always #50 CLK = ~CLK;

   sfm_mon #(.Z_WAIT_CYCLES(ZW)) i_dut (.CLK, .RST, .CYC_I, .STB_I,
      .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .IRQ, .BUS_VOLTAGE,
      .CUR_SAMPLE, .CUR_VALID, .CUR_SENSOR_ERR, .ENC_A,
      .ENC_B, .ENC_Z, .ENC_BREAK, .NVM_RD_DONE, .NVM_RD_ERR,
      .HALL_PHASE, .ENC_PHASE, .WIND_DIR, .ECHO_IN, .ECHO_OUT);
   sfm_echo_model i_echo (.clk(CLK), .echo_out(ECHO_OUT), .flip(flip),
      .echo_in(ECHO_IN));

   // ****************
   // Tasks
   // ****************
   task automatic ck(input string nm, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Classic single cycle; only the watchdog ends the wait for ack
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I <= w;
      ADR_I <= a;
      DAT_I <= d;
      do begin
         @(posedge CLK);
         n++;
      end while (ACK_O !== 1'b1);
      ck("ack latency", n, 32'd2);
      q = DAT_O;
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
   endtask
   task automatic rc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      ck(nm, q, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge CLK);
   endtask
   // Code, sticky status, clear on read, explicit code clear
   task automatic fc(input logic [7:0] c, input logic [8:0] s);
      rc("code", OFS_CODE, {24'h0, c});
      rc("status", OFS_STATUS, {23'h0, s});
      rc("status cleared", OFS_STATUS, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h1);
      rc("code cleared", OFS_CODE, 32'h0);
   endtask
   task automatic smp(input logic [15:0] v);
      @(posedge CLK);
      CUR_SAMPLE <= v;
      CUR_VALID <= 1'b1;
      @(posedge CLK);
      CUR_VALID <= 1'b0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #2000000;
      err_total++;
      $display("ERROR watchdog expected done seen timeout");
      stop_test();
   end

   // ****************
   // Tests
   // ****************
   initial begin
      int r, th;
      idle(6);
      RST <= 1'b0;
      rc("rated", OFS_RATED, 32'hdc);
      rc("mask", OFS_MASK, 32'h0);
      bus(1'b1, 8'h40, 32'hffff);
      rc("unmapped", 8'h40, 32'h0);
      @(posedge CLK) SEL_I <= 4'h2;
      bus(1'b1, OFS_RATED, 32'h1234);
      @(posedge CLK) SEL_I <= 4'hf;
      rc("lane merge", OFS_RATED, 32'h12dc);
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
         r = i ? 380 : 220;
         th = r * 9898 / 10000;
         bus(1'b1, OFS_RATED, r);
         rc("threshold", OFS_UVTH, th);
         @(posedge CLK) BUS_VOLTAGE <= 16'(th);
         rc("at threshold", OFS_STATUS, 32'h0);
         rc("bus voltage", OFS_BUSV, th);
         @(posedge CLK) BUS_VOLTAGE <= 16'(th - 1);
         @(posedge CLK) BUS_VOLTAGE <= 16'hffff;
         fc(CODE_UV, 9'h001);
      end
      $display("test undervoltage done");
      bus(1'b1, OFS_IRQMASK, 32'h1ff);
      @(posedge CLK) CUR_SENSOR_ERR <= 1'b1;
      @(posedge CLK) CUR_SENSOR_ERR <= 1'b0;
      idle(2);
      ck("irq set", {31'h0, IRQ}, 32'h1);
      bus(1'b1, OFS_IRQMASK, 32'h1fd);
      idle(1);
      ck("irq masked", {31'h0, IRQ}, 32'h0);
      rc("irq mask", OFS_IRQMASK, 32'h1fd);
      bus(1'b1, OFS_IRQMASK, 32'h1ff);
      fc(CODE_CURS, 9'h002);
      ck("irq cleared", {31'h0, IRQ}, 32'h0);
      $display("test interrupt done");
      @(posedge CLK) ENC_BREAK <= 1'b1;
      idle(6);
      @(posedge CLK) ENC_BREAK <= 1'b0;
      idle(8);
      fc(CODE_ENC, 9'h004);
      @(posedge CLK) ENC_A <= 1'b1;
      idle(6);
      rc("single line step", OFS_STATUS, 32'h0);
      @(posedge CLK) {ENC_A, ENC_B} <= 2'b01;
      idle(6);
      fc(CODE_ENC, 9'h004);
      @(posedge CLK) NVM_RD_DONE <= 1'b1;
      @(posedge CLK) NVM_RD_DONE <= 1'b0;
      rc("read good", OFS_STATUS, 32'h0);
      @(posedge CLK) NVM_RD_ERR <= 1'b1;
      @(posedge CLK) NVM_RD_DONE <= 1'b1;
      @(posedge CLK) NVM_RD_DONE <= 1'b0;
      fc(CODE_NVM, 9'h008);
      $display("test sensors done");
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, OFS_MASK, m ? 32'h4 : 32'h0);
         @(posedge CLK) ENC_PHASE <= PHASE_TOL;
         rc("phase in range", OFS_STATUS, 32'h0);
         @(posedge CLK) ENC_PHASE <= PHASE_TOL + 8'h01;
         @(posedge CLK) ENC_PHASE <= 8'h00;
         if (m) rc("phase masked", OFS_STATUS, 32'h0);
         else fc(CODE_PHASE, 9'h010);
      end
      $display("test phase done");
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, OFS_MASK, m ? 32'h8 : 32'h0);
         smp(16'd100);
         smp(16'd149);
         smp(16'd100);
         rc("small steps", OFS_STATUS, 32'h0);
         smp(16'd150);
         if (m) rc("jump masked", OFS_STATUS, 32'h0);
         else fc(CODE_JUMP, 9'h040);
      end
      $display("test current jump done");
      bus(1'b1, OFS_MASK, 32'h0);
      smp(16'd140);
      rc("not learning", OFS_STATUS, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h2);
      rc("learn flag", OFS_CTRL, 32'h2);
      smp(16'd150);
      rc("right way", OFS_STATUS, 32'h0);
      smp(16'd140);
      fc(CODE_WIND, 9'h080);
      $display("test winding done");
      bus(1'b1, OFS_CTRL, 32'h4);
      idle(ZW / 2);
      rc("index pending", OFS_STATUS, 32'h0);
      idle(ZW);
      fc(CODE_INDEX, 9'h100);
      bus(1'b1, OFS_CTRL, 32'h4);
      @(posedge CLK) ENC_Z <= 1'b1;
      idle(6);
      @(posedge CLK) ENC_Z <= 1'b0;
      idle(ZW + 10);
      rc("index seen", OFS_STATUS, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h0);
      $display("test index done");
      bus(1'b1, OFS_COMM, 32'h5aa5);
      idle(6);
      ck("echo out", {16'h0, ECHO_OUT}, 32'h5aa5);
      rc("link good", OFS_STATUS, 32'h0);
      rc("comm word", OFS_COMM, 32'h5aa5);
      @(posedge CLK) flip <= 16'h0100;
      bus(1'b1, OFS_COMM, 32'ha55a);
      idle(6);
      @(posedge CLK) flip <= 16'h0000;
      fc(CODE_COMM, 9'h020);
      $display("test link done");
      @(posedge CLK) CUR_SENSOR_ERR <= 1'b1;
      @(posedge CLK) CUR_SENSOR_ERR <= 1'b0;
      @(posedge CLK) NVM_RD_DONE <= 1'b1;
      @(posedge CLK) NVM_RD_DONE <= 1'b0;
      idle(2);
      fc(CODE_NVM, 9'h00a);
      @(posedge CLK) CUR_SENSOR_ERR <= 1'b1;
      @(posedge CLK) CUR_SENSOR_ERR <= 1'b0;
      idle(2);
      @(posedge CLK) RST <= 1'b1;
      idle(2);
      @(posedge CLK) RST <= 1'b0;
      rc("code after reset", OFS_CODE, 32'h0);
      $display("test latest code done");
      stop_test();
   end
endmodule // sfm_mon_bench

bind sfm_mon sfm_mon_chk i_chk (.CLK, .RST, .CYC_I, .STB_I, .WE_I,
   .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .IRQ, .CUR_SENSOR_ERR,
   .NVM_RD_DONE, .NVM_RD_ERR, .ECHO_OUT);

// File: sim/sfm_mon_chk.sv
// Port-level assertions for the servo fault monitor
`timescale 1ns/10ps
module sfm_mon_chk (
   input wire logic        CLK,            // System clock
   input wire logic        RST,            // Sync reset
   input wire logic        CYC_I,          // Bus cycle
   input wire logic        STB_I,          // Bus strobe
   input wire logic        WE_I,           // Bus write
   input wire logic [7:0]  ADR_I,          // Bus address
   input wire logic [3:0]  SEL_I,          // Byte lanes
   input wire logic [31:0] DAT_I,          // Write data
   input wire logic [31:0] DAT_O,          // Read data
   input wire logic        ACK_O,          // Acknowledge
   input wire logic        IRQ,            // Interrupt
   input wire logic        CUR_SENSOR_ERR, // Sensor failed
   input wire logic        NVM_RD_DONE,    // Memory read done
   input wire logic        NVM_RD_ERR,     // Memory read bad
   input wire logic [15:0] ECHO_OUT        // Word to motion side
);
   import sfm_pkg::*;
   // ****************
   // Helper logic
   // ****************
   logic       take;   // Request accepted at this edge
   logic [8:0] irq_en; // Shadow of the interrupt enables
   logic       mwr;    // Enable write taken at this edge

   // A held request is not taken again while ack stands
   assign take = CYC_I && STB_I && !ACK_O;
   // An enable write lands at the same edge as a coinciding event
   assign mwr  = take && WE_I && ADR_I == OFS_IRQMASK;

   // Enables tracked from bus writes so event checks know the mask
   always_ff @(posedge CLK) begin
      if (RST) begin
         irq_en <= IRQMASK_RST;
      end else if (mwr) begin
         if (SEL_I[0]) begin
            irq_en[7:0] <= DAT_I[7:0];
         end
         if (SEL_I[1]) begin
            irq_en[8] <= DAT_I[8];
         end
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // ****************
   // Assertions
   // ****************
   chk_ack_answer: assert property (take |=> ACK_O)
      else $error("request not acked next cycle");
   chk_ack_single: assert property (!take |=> !ACK_O)
      else $error("ack without a new request");
   chk_dat_hold: assert property (!(take && !WE_I) |=> $stable(DAT_O))
      else $error("read data moved without a read");
   chk_code_width: assert property (take && !WE_I && ADR_I == OFS_CODE
      |=> DAT_O[31:8] == 24'h0)
      else $error("fault code upper bits not zero");
   chk_unmapped_zero: assert property (take && !WE_I && ADR_I > OFS_UVTH
      |=> DAT_O == 32'h0)
      else $error("unmapped read not zero");
   chk_irq_sticky: assert property (IRQ && !take |=> IRQ)
      else $error("interrupt dropped without access");
   chk_curs_irq: assert property (CUR_SENSOR_ERR && irq_en[1] && !mwr
      |=> IRQ)
      else $error("sensor failure raised no interrupt");
   chk_nvm_irq: assert property (NVM_RD_DONE && NVM_RD_ERR && irq_en[3]
      && !mwr |=> IRQ)
      else $error("memory read error raised no interrupt");
   chk_echo_hold: assert property (!(take && WE_I && ADR_I == OFS_COMM)
      |=> $stable(ECHO_OUT))
      else $error("echo word moved without a write");
endmodule // sfm_mon_chk
